// File: include/irqhld_pkg.sv
// Package of constants and types for the interrupt request output stage.
// Functional notes
// - Config bits 31:24 hold the hold-off interval, one count per ten microseconds.
// - Writing zero to the interval disables hold-off, clears counter, releases pending requests.
// - A new non-zero interval governs every later interrupt.
// - The power event wake interrupt is never delayed by hold-off.
// - Writing one to self-clearing bit 14 restarts the hold-off interval.
// - Bit 13 reads one while a hold-off interval withholds the pin.
// - Bit 12 mirrors the internal interrupt line, ignoring enable and hold-off.
// - The internal line is high when any enabled status source is active.
// - With bit 8 clear the request pin stays deasserted; status unaffected.
// - Push-pull output: polarity bit clear gives active low, set gives active high.
// - Open-drain output ignores polarity and is always active low.
// - Bit 0 clear selects open-drain, set selects push-pull.
// - Writing one to an interrupt status bit clears it; zero leaves it.
package irqhld_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] IRQHLD_CFG_OFS = 8'h54;
  localparam logic [7:0] IRQHLD_STS_OFS = 8'h58;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int IRQHLD_INTV_LSB = 24;
  localparam int IRQHLD_INTV_W = 8;
  localparam int IRQHLD_RESTART_BIT = 14;
  localparam int IRQHLD_ACTIVE_BIT = 13;
  localparam int IRQHLD_MASTER_BIT = 12;
  localparam int IRQHLD_EN_BIT = 8;
  localparam int IRQHLD_POL_BIT = 4;
  localparam int IRQHLD_TYPE_BIT = 0;
  localparam int IRQHLD_PWR_BIT = 17;

  // ----------------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------------
  localparam logic [31:0] IRQHLD_CFG_RST = 32'h0000_0000;
  localparam logic [31:0] IRQHLD_STS_RST = 32'h0000_0000;
  localparam int IRQHLD_CLK_MHZ = 200;
  localparam int IRQHLD_STEP_US = 10;
  localparam int IRQHLD_STEP_CYC = IRQHLD_STEP_US * IRQHLD_CLK_MHZ;

  // Hold-off states, Gray coded along idle -> hold -> idle.
  typedef enum logic [1:0] {
    IRQHLD_IDLE = 2'b00,
    IRQHLD_HOLD = 2'b01
  } irqhld_state_t;

endpackage

// File: include/irqhld_tick_if.sv
// Interface carrying the hold-off tick controls between the two modules.
`timescale 1ns/100ps
interface irqhld_tick_if;
  logic restart;
  logic tick;
  modport ctl (output restart, input tick);
  modport gen (input restart, output tick);
endinterface

// File: src/irqhld_tick.sv
// Ten-microsecond tick generator used to time the hold-off interval.
`timescale 1ns/100ps
module irqhld_tick
  import irqhld_pkg::*;
#(
  parameter int STEP_CYC = IRQHLD_STEP_CYC
) (
  // Clock and control
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Tick link
  irqhld_tick_if.gen tk
);

  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  wire logic at_end = (cnt_q == 16'(STEP_CYC - 1));

  // A restart realigns the step so a fresh interval is full length.
  assign cnt_d = (tk.restart || at_end) ? 16'h0000 : cnt_q + 16'h0001;
  assign tk.tick = at_end && !tk.restart;

  // Free running step counter.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cnt_q <= 16'h0000;
    end else if (clk_en) begin
      cnt_q <= cnt_d;
    end
  end

endmodule // irqhld_tick

// File: src/irqhld_top.sv
// Interrupt request output stage with enable, polarity, buffer type and hold-off.
`timescale 1ns/100ps
module irqhld_top
  import irqhld_pkg::*;
#(
  parameter int STEP_CYC = IRQHLD_STEP_CYC
) (
  // Clock, enable and resets
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic soft_rst,
  input wire logic clk_en,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  // Interrupt sources
  input wire logic [31:0] int_event,
  input wire logic [31:0] int_enable,
  // Request pin
  output logic irq_out,
  output logic irq_oe
);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [7:0] intv_q;
  logic en_q;
  logic pol_q;
  logic type_q;
  logic [31:0] sts_q;
  logic [31:0] sts_d;
  logic [7:0] hcnt_q;
  logic [7:0] hcnt_d;
  logic pin_q;
  logic [31:0] rdata_q;
  irqhld_state_t st_q;
  irqhld_state_t st_d;
  irqhld_tick_if tk ();

  irqhld_tick #(.STEP_CYC(STEP_CYC)) u_tick (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst | soft_rst),
    .clk_en(clk_en),
    .tk(tk)
  );

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  wire logic cfg_wr = reg_wr && (reg_addr == IRQHLD_CFG_OFS);
  wire logic sts_wr = reg_wr && (reg_addr == IRQHLD_STS_OFS);
  wire logic [7:0] new_intv = reg_wdata[IRQHLD_INTV_LSB +: IRQHLD_INTV_W];
  wire logic intv_zero_wr = cfg_wr && (new_intv == 8'h00);
  wire logic restart = cfg_wr && reg_wdata[IRQHLD_RESTART_BIT];
  wire logic [7:0] live_intv = cfg_wr ? new_intv : intv_q;

  // Status: hardware set wins over a same-cycle write-one clear.
  assign sts_d = int_event | (sts_q & ~(sts_wr ? reg_wdata : 32'h0000_0000));

  // Internal line from enabled sources; power event split out from hold-off.
  wire logic [31:0] pwr_mask = 32'h0000_0001 << IRQHLD_PWR_BIT;
  wire logic master = |(sts_q & int_enable);
  wire logic pwr_req = |(sts_q & int_enable & pwr_mask);
  wire logic holding = (st_q == IRQHLD_HOLD);
  wire logic assert_req = en_q && (pwr_req || (master && !holding));

  // Hold-off starts when the pin falls inactive with a non-zero interval.
  wire logic pin_fall = pin_q && !assert_req;
  wire logic hold_done = tk.tick && (hcnt_q + 8'h01 >= intv_q);
  assign tk.restart = restart || pin_fall;

  // Hold-off state machine.
  always_comb begin
    st_d = st_q;
    hcnt_d = hcnt_q;
    case (st_q)
      IRQHLD_IDLE: begin
        if ((pin_fall || restart) && live_intv != 8'h00) begin
          st_d = IRQHLD_HOLD;
          hcnt_d = 8'h00;
        end
      end
      IRQHLD_HOLD: begin
        if (intv_zero_wr) begin
          st_d = IRQHLD_IDLE;
          hcnt_d = 8'h00;
        end else if (restart) begin
          hcnt_d = 8'h00;
        end else if (hold_done) begin
          st_d = IRQHLD_IDLE;
          hcnt_d = 8'h00;
        end else if (tk.tick) begin
          hcnt_d = hcnt_q + 8'h01;
        end
      end
      default: begin
        st_d = IRQHLD_IDLE;
        hcnt_d = 8'h00;
      end
    endcase
  end

  // Pin encoding: open-drain is always active low, push-pull follows polarity.
  wire logic od_oe = assert_req;
  wire logic pp_lvl = pol_q ? assert_req : !assert_req;

  // Read mux; reserved bits read zero.
  wire logic [31:0] cfg_rd = {intv_q, 9'h000, 1'b0, holding, master, 3'h0, en_q,
                              3'h0, pol_q, 3'h0, type_q};
  wire logic [31:0] rd_mux = (reg_addr == IRQHLD_CFG_OFS) ? cfg_rd :
                             (reg_addr == IRQHLD_STS_OFS) ? sts_q : 32'h0000_0000;

  // ----------------------------------------------------------------------
  // State update
  // ----------------------------------------------------------------------
  // Polarity and type ignore software reset so the board wiring stays valid.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pol_q <= IRQHLD_CFG_RST[IRQHLD_POL_BIT];
      type_q <= IRQHLD_CFG_RST[IRQHLD_TYPE_BIT];
    end else if (clk_en && cfg_wr) begin
      pol_q <= reg_wdata[IRQHLD_POL_BIT];
      type_q <= reg_wdata[IRQHLD_TYPE_BIT];
    end
  end

  // Remaining control and status state clears on either reset.
  always_ff @(posedge ref_clk) begin
    if (sys_rst || soft_rst) begin
      intv_q <= IRQHLD_CFG_RST[31:24];
      en_q <= 1'b0;
      sts_q <= IRQHLD_STS_RST;
      st_q <= IRQHLD_IDLE;
      hcnt_q <= 8'h00;
      pin_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else if (clk_en) begin
      if (cfg_wr) begin
        intv_q <= new_intv;
        en_q <= reg_wdata[IRQHLD_EN_BIT];
      end
      sts_q <= sts_d;
      st_q <= st_d;
      hcnt_q <= hcnt_d;
      pin_q <= assert_req;
      if (reg_rd) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // Pin drive: open-drain only drives while asserted.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irq_out <= 1'b1;
      irq_oe <= 1'b0;
    end else if (clk_en) begin
      irq_out <= type_q ? pp_lvl : 1'b0;
      irq_oe <= type_q ? 1'b1 : od_oe;
    end
  end

  assign reg_rdata = rdata_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_disabled_pin_idle: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (clk_en && !en_q && type_q == 1'b0) |=> !irq_oe)
    else $error("Request pin driven while output disabled.");

  a_od_active_low: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (clk_en && type_q == 1'b0) |=> (irq_out == 1'b0))
    else $error("Open-drain output drove a high level.");

  // The pin level is launched with the polarity of the cycle before, hence the look back.
  a_pp_polarity: assert property (@(posedge ref_clk) disable iff (sys_rst || soft_rst)
    (clk_en && type_q) |=> irq_out == ($past(pol_q) ? pin_q : !pin_q))
    else $error("Push-pull level does not follow polarity.");

  a_zero_clears_hold: assert property (@(posedge ref_clk) disable iff (sys_rst || soft_rst)
    (clk_en && intv_zero_wr) |=> !holding)
    else $error("Zero interval did not end hold-off.");

  a_restart_starts: assert property (@(posedge ref_clk) disable iff (sys_rst || soft_rst)
    (clk_en && restart && new_intv != 8'h00) |=> holding && hcnt_q == 8'h00)
    else $error("Restart did not begin a fresh interval.");

  a_hold_blocks_pin: assert property (@(posedge ref_clk) disable iff (sys_rst || soft_rst)
    (holding && !pwr_req) |-> !assert_req)
    else $error("Request asserted during hold-off.");

  a_power_bypass: assert property (@(posedge ref_clk) disable iff (sys_rst || soft_rst)
    (en_q && pwr_req) |-> assert_req)
    else $error("Power event interrupt was delayed.");

  a_w1c_clears: assert property (@(posedge ref_clk) disable iff (sys_rst || soft_rst)
    (clk_en && sts_wr && reg_wdata[0] && !int_event[0]) |=> !sts_q[0])
    else $error("Write one did not clear status bit.");

  a_soft_keeps_pol: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (soft_rst && !cfg_wr) |=> $stable(pol_q) && $stable(type_q))
    else $error("Software reset altered pin configuration.");

endmodule // irqhld_top

// File: verif/irqhld_host_model.sv
// Host side model that resolves the shared interrupt request wire.
`timescale 1ns/100ps
module irqhld_host_model (
  // Request pin from the device
  input wire logic irq_out,
  input wire logic irq_oe,
  // Wire level seen by the host
  output logic irq_wire
);
  // A board pull-up holds the wire high while no one drives it, so a released pin reads idle.
  assign irq_wire = irq_oe ? irq_out : 1'b1;
endmodule // irqhld_host_model

// File: verif/tb.sv
// Self-checking testbench for the interrupt request output stage.
`timescale 1ns/100ps
module tb;
  import irqhld_pkg::*;
  // ----------------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic soft_rst = 1'b0;
  logic clk_en = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic [31:0] int_event = 32'h0;
  logic [31:0] int_enable = 32'h0002_0001;
  logic irq_out;
  logic irq_oe;
  logic irq_wire;
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;
  irqhld_top #(.STEP_CYC(4)) irqhld_top_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .soft_rst(soft_rst), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .int_event(int_event),
    .int_enable(int_enable), .irq_out(irq_out), .irq_oe(irq_oe));
  irqhld_host_model irqhld_host_model_i (.irq_out(irq_out), .irq_oe(irq_oe),
    .irq_wire(irq_wire));
  // Clock of 5 ns period.
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Cuts a hang short; the tests need well under this many cycles.
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      conclude();
    end
  end
  // ----------------------------------------------------------------------
  // Access and compare tasks
  // ----------------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic chk_reg(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_pin(input logic e);
    tests_run++;
    if (irq_wire !== e) begin
      failures++;
      $display("Error irq_wire expected %b seen %b", e, irq_wire);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask
  // Read data is registered, so it is looked at one full cycle after the strobe.
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    @(negedge ref_clk);
    chk_reg($sformatf("reg_%h", a), e, reg_rdata);
  endtask
  task automatic ev(input int b);
    @(negedge ref_clk);
    int_event[b] = 1'b1;
    @(negedge ref_clk);
    int_event = 32'h0;
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    cyc(3);
    sys_rst = 1'b0;
    rd(IRQHLD_CFG_OFS, 32'h0);
    rd(IRQHLD_STS_OFS, 32'h0);
    rd(8'h5C, 32'h0);
    // Open-drain output drives low whatever the polarity bit says; push-pull follows the polarity bit.
    wr(IRQHLD_CFG_OFS, 32'h0000_0100);
    ev(0);
    cyc(3);
    chk_pin(1'b0);
    rd(IRQHLD_CFG_OFS, 32'h0000_1100);
    wr(IRQHLD_CFG_OFS, 32'h0000_0110);
    cyc(3);
    chk_pin(1'b0);
    wr(IRQHLD_CFG_OFS, 32'h0000_0111);
    cyc(3);
    chk_pin(1'b1);
    wr(IRQHLD_CFG_OFS, 32'h0000_0101);
    cyc(3);
    chk_pin(1'b0);
    // Disabled output stays idle while status and master bit remain.
    wr(IRQHLD_CFG_OFS, 32'h0000_0001);
    cyc(3);
    chk_pin(1'b1);
    rd(IRQHLD_CFG_OFS, 32'h0000_1001);
    wr(IRQHLD_STS_OFS, 32'h0);
    rd(IRQHLD_STS_OFS, 32'h0000_0001);
    wr(IRQHLD_STS_OFS, 32'h0000_0001);
    rd(IRQHLD_STS_OFS, 32'h0);
    rd(IRQHLD_CFG_OFS, 32'h0000_0001);
    // Hold-off of 16 ticks of 4 cycles withholds a new request.
    wr(IRQHLD_CFG_OFS, 32'h1000_0101);
    ev(0);
    cyc(3);
    chk_pin(1'b0);
    wr(IRQHLD_STS_OFS, 32'h0000_0001);
    cyc(3);
    chk_pin(1'b1);
    rd(IRQHLD_CFG_OFS, 32'h1000_2101);
    ev(0);
    cyc(3);
    chk_pin(1'b1);
    cyc(80);
    chk_pin(1'b0);
    rd(IRQHLD_CFG_OFS, 32'h1000_1101);
    // The power event passes through a running hold-off.
    wr(IRQHLD_STS_OFS, 32'h0000_0001);
    cyc(3);
    ev(17);
    cyc(3);
    chk_pin(1'b0);
    wr(IRQHLD_STS_OFS, 32'h0002_0000);
    cyc(3);
    ev(0);
    cyc(3);
    chk_pin(1'b1);
    wr(IRQHLD_CFG_OFS, 32'h0000_0101);
    cyc(3);
    chk_pin(1'b0);
    rd(IRQHLD_CFG_OFS, 32'h0000_1101);
    // Restart from idle opens a fresh interval; the bit itself reads zero.
    wr(IRQHLD_STS_OFS, 32'h0000_0001);
    cyc(3);
    wr(IRQHLD_CFG_OFS, 32'h1000_4101);
    rd(IRQHLD_CFG_OFS, 32'h1000_2101);
    ev(0);
    cyc(3);
    chk_pin(1'b1);
    // Software reset keeps polarity and buffer type only.
    wr(IRQHLD_CFG_OFS, 32'h0000_0111);
    @(negedge ref_clk);
    soft_rst = 1'b1;
    @(negedge ref_clk);
    soft_rst = 1'b0;
    rd(IRQHLD_CFG_OFS, 32'h0000_0011);
    @(negedge ref_clk);
    sys_rst = 1'b1;
    @(negedge ref_clk);
    sys_rst = 1'b0;
    rd(IRQHLD_CFG_OFS, 32'h0);
    conclude();
  end
endmodule // tb
